// ===== logic/sqd_pkg.sv
package sqd_pkg;
    // word layout
    localparam int          WORD_W       = 16;
    localparam int          MODE_HI      = 15;
    localparam int          MODE_LO      = 14;
    localparam int          PARITY_BIT   = 13;
    localparam int          RW_BIT       = 12;
    localparam int          SWR_BIT      = 11;
    localparam int          SUB_BIT      = 10;
    localparam int          CL_HI        = 9;
    localparam int          CL_LO        = 8;
    localparam int          PU_BIT       = 1;
    localparam int          SRST_BIT     = 0;
    localparam int          BITCNT_W     = 5;
    localparam logic [4:0]  FRAME_BITS   = 5'h10;
    // mode groups
    localparam logic [1:0]  MODE_CFG     = 2'h0;
    localparam logic [1:0]  MODE_DEP     = 2'h1;
    localparam logic [1:0]  MODE_DIAG    = 2'h2;
    localparam logic [1:0]  MODE_MON     = 2'h3;
    // deployment patterns in bits 12..8
    localparam logic [4:0]  ARM_PATTERN  = 5'h19;
    localparam logic [4:0]  FIRE_PATTERN = 5'h00;
    // soft reset sequence bytes
    localparam logic [7:0]  SRST_FIRST   = 8'hAA;
    localparam logic [7:0]  SRST_SECOND  = 8'h55;
    // fixed responses
    localparam logic [15:0] RESP_POR     = 16'h0000;
    localparam logic [15:0] RESP_PARITY  = 16'hD000;
    localparam logic [15:0] RESP_CLOCKS  = 16'hD003;
    localparam logic [15:0] RESP_SRST    = 16'h2003;
    // reset values
    localparam logic [1:0]  CL_RESET     = 2'h0;
    localparam logic [1:0]  LATCH_RESET  = 2'h0;
    // wishbone map (byte addresses)
    localparam logic [3:0]  ADDR_CTRL    = 4'h0;
    localparam logic [3:0]  ADDR_STATUS  = 4'h4;
    localparam logic [3:0]  ADDR_CMD     = 4'h8;
    localparam logic [3:0]  ADDR_DIAG    = 4'hC;
    localparam logic [31:0] CTRL_RESET   = 32'h00000000;

    typedef enum logic [3:0] {
        SQD_ST_IDLE  = 4'b0001,
        SQD_ST_SHIFT = 4'b0010,
        SQD_ST_EXEC  = 4'b0100,
        SQD_ST_LOAD  = 4'b1000
    } sqd_state_e;
endpackage

// ===== logic/sqd_sync3.sv
`timescale 1ns/1ps
module sqd_sync3 #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic [2:0] stage_r;
    logic       level_r;

    // change counts once stages two and three agree
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stage_r <= {3{RESET_VAL}};
            level_r <= RESET_VAL;
        end else begin
            stage_r <= {stage_r[1:0], pin_in};
            if (stage_r[1] == stage_r[2]) begin
                level_r <= stage_r[2];
            end
        end
    end

    wire agree = (stage_r[1] == stage_r[2]);
    assign level = level_r;
    assign rise  = agree & stage_r[2] & ~level_r;
    assign fall  = agree & ~stage_r[2] & level_r;
endmodule // sqd_sync3

// ===== logic/sqd_spi_decoder.sv
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module sqd_spi_decoder (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        spi_sclk,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    output logic             spi_miso_oe,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic [1:0]       firing_current_setting,
    output logic [1:0]       fire_latch_setting,
    output logic [3:0]       armed_channels,
    output logic [3:0]       fire_channels,
    output logic             fire_strobe,
    output logic [2:0]       diag_test_sel,
    output logic             diag_strobe,
    output logic [1:0]       monitor_sel,
    output logic             monitor_strobe
);
    import sqd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic sclk_lvl, sclk_rise, sclk_fall;
    logic cs_lvl, cs_rise, cs_fall;
    logic mosi_lvl;

    sqd_sync3 #(.RESET_VAL(1'b0)) u_sclk (
        .ref_clk(ref_clk), .nrst(nrst), .pin_in(spi_sclk),
        .level(sclk_lvl), .rise(sclk_rise), .fall(sclk_fall));
    sqd_sync3 #(.RESET_VAL(1'b1)) u_cs (
        .ref_clk(ref_clk), .nrst(nrst), .pin_in(spi_cs_n),
        .level(cs_lvl), .rise(cs_rise), .fall(cs_fall));
    sqd_sync3 #(.RESET_VAL(1'b0)) u_mosi (
        .ref_clk(ref_clk), .nrst(nrst), .pin_in(spi_mosi),
        .level(mosi_lvl), .rise(), .fall());

    ////////////////////////////////////////////////////////////////////////
    // state
    sqd_state_e           state_r, state_nxt;
    logic [WORD_W-1:0]    rx_r;
    logic [WORD_W-1:0]    tx_r;
    logic [WORD_W-1:0]    resp_r, resp_nxt;
    logic [BITCNT_W-1:0]  bits_r;
    logic [1:0]           cl_r, cl_nxt;
    logic [1:0]           latch_r, latch_nxt;
    logic                 pu_r;
    logic                 srst_half_r, srst_half_nxt;
    logic                 arm_ok_r, arm_ok_nxt;
    logic [3:0]           arm_r, arm_nxt;
    logic                 soft_rst_r;
    logic                 word_ok_r;
    logic [31:0]          ctrl_r;
    logic [WORD_W-1:0]    last_cmd_r;
    logic                 wb_ack_r;

    ////////////////////////////////////////////////////////////////////////
    // frame engine
    wire frame_end  = cs_rise;
    wire shift_in   = (state_r == SQD_ST_SHIFT) & sclk_rise;
    wire rx_parity  = ^rx_r;
    wire count_ok   = (bits_r == FRAME_BITS);
    wire [1:0] mode = rx_r[MODE_HI:MODE_LO];
    wire is_cfg     = (mode == MODE_CFG);
    wire is_dep     = (mode == MODE_DEP);
    wire is_diag    = (mode == MODE_DIAG);
    wire is_mon     = (mode == MODE_MON);
    wire is_cfg1    = is_cfg & ~rx_r[SUB_BIT];
    wire is_cfg2    = is_cfg & rx_r[SUB_BIT];
    wire cfg_write  = rx_r[RW_BIT];
    wire swr_step   = cfg_write & rx_r[SWR_BIT];
    wire [4:0] dep_pat = rx_r[RW_BIT:CL_LO];
    wire is_arm     = is_dep & (dep_pat == ARM_PATTERN);
    wire is_fire    = is_dep & (dep_pat == FIRE_PATTERN);
    wire known      = is_cfg | is_arm | is_fire | is_diag | is_mon;
    wire good_word  = count_ok & rx_parity & known;
    wire srst_done  = good_word & is_cfg1 & swr_step & srst_half_r
                      & (rx_r[7:0] == SRST_SECOND);
    wire tx_out     = tx_r[WORD_W-1];
    // echo fields plus stored current and powered-up flag
    wire [WORD_W-1:0] cfg1_raw = {MODE_CFG, 1'b0, rx_r[RW_BIT], rx_r[SWR_BIT], 1'b0,
                                  cl_nxt, 6'h00, pu_r, 1'b0};
    wire [WORD_W-1:0] cfg2_raw = {MODE_CFG, 1'b0, rx_r[RW_BIT], 2'h1, latch_nxt, 8'h00};
    wire [WORD_W-1:0] dep_raw  = {rx_r[15:4], arm_nxt};

    function automatic logic [WORD_W-1:0] with_parity(input logic [WORD_W-1:0] w);
        logic [WORD_W-1:0] t;
        t = w;
        t[PARITY_BIT] = 1'b0;
        t[PARITY_BIT] = ~(^t);
        return t;
    endfunction

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SQD_ST_IDLE:  if (cs_fall) state_nxt = SQD_ST_LOAD;
            SQD_ST_LOAD:  state_nxt = SQD_ST_SHIFT;
            SQD_ST_SHIFT: if (frame_end) state_nxt = SQD_ST_EXEC;
            SQD_ST_EXEC:  state_nxt = SQD_ST_IDLE;
        endcase
    end

    // decode of a finished frame into next response and stored settings
    always_comb begin
        cl_nxt        = cl_r;
        latch_nxt     = latch_r;
        arm_nxt       = arm_r;
        arm_ok_nxt    = 1'b0;
        srst_half_nxt = 1'b0;
        resp_nxt      = with_parity(cfg1_raw);
        if (!count_ok) begin
            resp_nxt = RESP_CLOCKS;
        end else if (!rx_parity || !known) begin
            resp_nxt = RESP_PARITY;
        end else if (is_cfg1) begin
            if (cfg_write && !rx_r[SWR_BIT]) begin
                cl_nxt = rx_r[CL_HI:CL_LO];
            end
            // a step leaves the current code alone
            srst_half_nxt = swr_step & (rx_r[7:0] == SRST_FIRST);
            resp_nxt = with_parity(cfg1_raw);
        end else if (is_cfg2) begin
            if (cfg_write) begin
                latch_nxt = rx_r[CL_HI:CL_LO];
            end
            resp_nxt = with_parity(cfg2_raw);
        end else if (is_arm) begin
            arm_nxt    = rx_r[3:0];
            arm_ok_nxt = 1'b1;
            resp_nxt   = with_parity(dep_raw);
        end else if (is_fire) begin
            arm_nxt  = arm_ok_r ? arm_r : 4'h0;
            resp_nxt = with_parity(dep_raw);
        end else begin
            resp_nxt = with_parity({rx_r[15:10], 10'h000});
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= SQD_ST_IDLE;
            bits_r  <= '0;
            rx_r    <= '0;
            tx_r    <= '0;
        end else begin
            state_r <= state_nxt;
            if (state_r == SQD_ST_LOAD) begin
                bits_r <= '0;
                tx_r   <= resp_r;
            end else if (shift_in) begin
                rx_r <= {rx_r[WORD_W-2:0], mosi_lvl};
                if (bits_r != 5'h1F) begin
                    bits_r <= bits_r + 5'h01;
                end
            end else if ((state_r == SQD_ST_SHIFT) && sclk_fall) begin
                tx_r <= {tx_r[WORD_W-2:0], 1'b0};
            end
        end
    end

    // soft reset clears the settings below; it loads RESP_SRST and sets pu_r
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            resp_r      <= RESP_POR;
            cl_r        <= CL_RESET;
            latch_r     <= LATCH_RESET;
            pu_r        <= 1'b0;
            srst_half_r <= 1'b0;
            arm_ok_r    <= 1'b0;
            arm_r       <= 4'h0;
            soft_rst_r  <= 1'b0;
            word_ok_r   <= 1'b0;
            last_cmd_r  <= '0;
        end else if (state_r == SQD_ST_EXEC) begin
            word_ok_r  <= good_word;
            last_cmd_r <= rx_r;
            if (srst_done) begin
                resp_r      <= RESP_SRST;
                cl_r        <= CL_RESET;
                latch_r     <= LATCH_RESET;
                pu_r        <= 1'b1;
                srst_half_r <= 1'b0;
                arm_ok_r    <= 1'b0;
                arm_r       <= 4'h0;
                soft_rst_r  <= 1'b1;
            end else begin
                resp_r      <= resp_nxt;
                cl_r        <= cl_nxt;
                latch_r     <= latch_nxt;
                srst_half_r <= srst_half_nxt & good_word;
                arm_ok_r    <= arm_ok_nxt & good_word;
                arm_r       <= good_word ? arm_nxt : arm_r;
                soft_rst_r  <= 1'b0;
            end
        end else if (state_r == SQD_ST_LOAD) begin
            pu_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strobes to the analog side
    logic fire_r, diag_r, mon_r;
    logic [3:0] fire_ch_r;
    logic [2:0] diag_sel_r;
    logic [1:0] mon_sel_r;

    wire exec_ok = (state_r == SQD_ST_EXEC) & good_word & ~ctrl_r[0];

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fire_r     <= 1'b0;
            diag_r     <= 1'b0;
            mon_r      <= 1'b0;
            fire_ch_r  <= 4'h0;
            diag_sel_r <= 3'h0;
            mon_sel_r  <= 2'h0;
        end else begin
            fire_r <= exec_ok & is_fire & arm_ok_r;
            diag_r <= exec_ok & is_diag;
            mon_r  <= exec_ok & is_mon;
            if (exec_ok & is_fire & arm_ok_r) begin
                fire_ch_r <= rx_r[3:0] & arm_r;
            end
            if (exec_ok & is_diag) begin
                diag_sel_r <= rx_r[11:9];
            end
            if (exec_ok & is_mon) begin
                mon_sel_r <= rx_r[11:10];
            end
        end
    end

    assign firing_current_setting = cl_r;
    assign fire_latch_setting     = latch_r;
    assign armed_channels         = arm_r;
    assign fire_channels          = fire_ch_r;
    assign fire_strobe            = fire_r;
    assign diag_test_sel          = diag_sel_r;
    assign diag_strobe            = diag_r;
    assign monitor_sel            = mon_sel_r;
    assign monitor_strobe         = mon_r;
    assign spi_miso               = tx_out;
    assign spi_miso_oe            = ~cs_lvl;

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave
    wire wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_r;
    wire sel_ctrl = (wb_adr_i == ADDR_CTRL);
    wire [31:0] rd_mux =
        sel_ctrl                  ? ctrl_r :
        (wb_adr_i == ADDR_STATUS) ? {24'h0, soft_rst_r, word_ok_r, pu_r, srst_half_r, arm_ok_r,
                                     1'b0, cl_r} :
        (wb_adr_i == ADDR_CMD)    ? {16'h0, last_cmd_r} :
        (wb_adr_i == ADDR_DIAG)   ? {16'h0, resp_r} : 32'h0;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_r <= 1'b0;
            wb_dat_o <= '0;
            ctrl_r   <= CTRL_RESET;
        end else begin
            wb_ack_r <= wb_req;
            if (wb_req) begin
                wb_dat_o <= rd_mux;
                if (wb_we_i && sel_ctrl && wb_sel_i[0]) begin
                    ctrl_r[7:0] <= wb_dat_i[7:0];
                end
            end
        end
    end
    assign wb_ack_o = wb_ack_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_srst_exec;
        (state_r == SQD_ST_EXEC) && srst_done;
    endsequence

    property p_parity;
        @(posedge ref_clk) disable iff (!nrst)
        (state_r == SQD_ST_LOAD) |=> (^tx_r) || (tx_r == RESP_POR);
    endproperty
    a_parity: assert property (p_parity) else $error("response parity even");

    property p_srst_resp;
        @(posedge ref_clk) disable iff (!nrst)
        s_srst_exec |=> (resp_r == RESP_SRST) && (cl_r == CL_RESET) && !arm_ok_r;
    endproperty
    a_srst_resp: assert property (p_srst_resp) else $error("soft reset response wrong");

    property p_clocks;
        @(posedge ref_clk) disable iff (!nrst)
        (state_r == SQD_ST_EXEC) && !count_ok |=> resp_r == RESP_CLOCKS;
    endproperty
    a_clocks: assert property (p_clocks) else $error("bad clock count not flagged");

    property p_bad_parity;
        @(posedge ref_clk) disable iff (!nrst)
        (state_r == SQD_ST_EXEC) && count_ok && !rx_parity |=> resp_r == RESP_PARITY;
    endproperty
    a_bad_parity: assert property (p_bad_parity) else $error("parity error not flagged");

    property p_read_keeps;
        @(posedge ref_clk) disable iff (!nrst)
        (state_r == SQD_ST_EXEC) && is_cfg && !cfg_write && !srst_done |=> $stable(cl_r) && $stable(latch_r);
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("read changed setting");

    property p_cl_write;
        @(posedge ref_clk) disable iff (!nrst)
        (state_r == SQD_ST_EXEC) && good_word && is_cfg1 && cfg_write && !rx_r[SWR_BIT]
        |=> cl_r == $past(rx_r[CL_HI:CL_LO]);
    endproperty
    a_cl_write: assert property (p_cl_write) else $error("current not stored");

    property p_fire_needs_arm;
        @(posedge ref_clk) disable iff (!nrst)
        fire_strobe |-> $past(arm_ok_r, 2);
    endproperty
    a_fire_needs_arm: assert property (p_fire_needs_arm) else $error("fire without arm");

    property p_next_frame;
        @(posedge ref_clk) disable iff (!nrst)
        (state_r == SQD_ST_LOAD) |=> tx_r == $past(resp_r);
    endproperty
    a_next_frame: assert property (p_next_frame) else $error("response not loaded");

    property p_pu;
        @(posedge ref_clk) disable iff (!nrst)
        (state_r == SQD_ST_LOAD) |=> pu_r;
    endproperty
    a_pu: assert property (p_pu) else $error("powered-up flag not set");
endmodule // sqd_spi_decoder

// ===== sim/sqd_host_model.sv
`timescale 1ns/1ps
module sqd_host_model #(
    parameter int HALF_NS = 100
) (
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    input  wire logic spi_miso
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // n other than 16 makes a clock-count fault; slow stretches the low phase
    task automatic xfer(input logic [31:0] w, input int n, input int slow, output logic [15:0] r);
        r = 16'h0000;
        #7;
        spi_cs_n = 1'b0;
        #(3 * HALF_NS);
        for (int i = n - 1; i >= 0; i--) begin
            spi_mosi = w[i];
            #(HALF_NS * slow);
            r = {r[14:0], spi_miso};
            spi_sclk = 1'b1;
            #(HALF_NS);
            spi_sclk = 1'b0;
        end
        #(HALF_NS);
        spi_cs_n = 1'b1;
        // a released line must not keep its last level
        spi_mosi = ~spi_mosi;
        #(4 * HALF_NS);
    endtask
endmodule // sqd_host_model

// ===== sim/tb_squib_spi_command_decoder.sv
`timescale 1ns/1ps
module tb_squib_spi_command_decoder;
    import sqd_pkg::*;
    localparam logic [16:0] NA = 17'h10000;
    logic        ref_clk, nrst, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, wb_cyc_i, wb_stb_i;
    logic        wb_we_i, wb_ack_o, fire_strobe, diag_strobe, monitor_strobe;
    logic [1:0]  firing_current_setting, fire_latch_setting, monitor_sel;
    logic [2:0]  diag_test_sel;
    logic [3:0]  wb_adr_i, wb_sel_i, armed_channels, fire_channels;
    logic [15:0] rsp, last_w;
    logic [16:0] prev;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    wire         miso_line;
    int          failures, samples_checked, cycles, n_fire, n_diag, n_mon, n0, spd;

    sqd_spi_decoder dut (
        .ref_clk(ref_clk), .nrst(nrst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .firing_current_setting(firing_current_setting),
        .fire_latch_setting(fire_latch_setting), .armed_channels(armed_channels),
        .fire_channels(fire_channels), .fire_strobe(fire_strobe), .diag_test_sel(diag_test_sel),
        .diag_strobe(diag_strobe), .monitor_sel(monitor_sel), .monitor_strobe(monitor_strobe)
    );
    sqd_host_model host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(miso_line));
    // no pull on the response line: a released line shows the inverse, never a stale level
    assign miso_line = spi_miso_oe ? spi_miso : ~spi_miso;

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // strobes are one cycle wide, so they are counted here rather than polled
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (fire_strobe === 1'b1) n_fire <= n_fire + 1;
        if (diag_strobe === 1'b1) n_diag <= n_diag + 1;
        if (monitor_strobe === 1'b1) n_mon <= n_mon + 1;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end
////////////////////////////////////////////////////////////
    function automatic logic [15:0] par(input logic [15:0] w);
        par = w;
        par[PARITY_BIT] = ~^{w[15:14], w[12:0]};
    endfunction
    // ctl is {write, reset select, current code}
    function automatic logic [15:0] cfg(input logic [3:0] ctl, input logic [7:0] lo);
        cfg = par({MODE_CFG, 1'b0, ctl[3:2], 1'b0, ctl[1:0], lo});
    endfunction
    function automatic logic [16:0] rs(input logic [3:0] ctl);
        rs = {1'b0, cfg(ctl, 8'h02)};
    endfunction
    function automatic logic [15:0] dep(input logic [4:0] pat, input logic [3:0] ch);
        dep = par({MODE_DEP, 1'b0, pat, 4'h0, ch});
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tx(input logic [15:0] w, input logic [16:0] exp);
        host.xfer({16'h0, w}, 16, spd, rsp);
        last_w = w;
        if (exp[16] === 1'b0) chk({16'h0, rsp}, {16'h0, exp[15:0]});
    endtask
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
////////////////////////////////////////////////////////////
    task automatic t_config();
        tx(cfg(4'h3, 8'h00), 17'h00000);
        chk(firing_current_setting, 2'h0);
        prev = rs(4'h0);
        for (int i = 1; i <= 4; i++) begin
            tx(cfg({2'h2, i[1:0]}, i[0] ? SRST_FIRST : SRST_SECOND), prev);
            chk(firing_current_setting, i[1:0]);
            prev = rs({2'h2, i[1:0]});
        end
        tx(cfg(4'hB, 8'h00), prev);
        tx(cfg(4'h1, 8'hFF), rs(4'hB));
        chk(firing_current_setting, 2'h3);
        tx(cfg(4'hC, 8'h12), rs(4'h3));
        chk(firing_current_setting, 2'h3);
    endtask
    task automatic t_soft_reset();
        tx(cfg(4'hC, SRST_SECOND), rs(4'hF));
        tx(cfg(4'hC, SRST_FIRST), rs(4'hF));
        tx(cfg(4'h0, 8'h00), rs(4'hF));
        tx(cfg(4'hC, SRST_SECOND), rs(4'h3));
        chk(firing_current_setting, 2'h3);
        tx(dep(ARM_PATTERN, 4'hB), rs(4'hF));
        chk(armed_channels, 4'hB);
        tx(cfg(4'hC, SRST_FIRST), NA);
        tx(cfg(4'hC, SRST_SECOND), rs(4'hF));
        chk(firing_current_setting, 2'h0);
        chk(armed_channels, 4'h0);
        tx(cfg(4'h0, 8'h00), 17'h02003);
        tx(cfg(4'hA, 8'h00), rs(4'h0));
    endtask
    task automatic t_faults();
        tx(cfg(4'h9, 8'h00) ^ 16'h2000, rs(4'hA));
        chk(firing_current_setting, 2'h2);
        tx(cfg(4'hC, SRST_FIRST), 17'h0D000);
        host.xfer({16'h0, cfg(4'h9, 8'h00)}, 15, 1, rsp);
        tx(cfg(4'hC, SRST_SECOND), 17'h0D003);
        chk(firing_current_setting, 2'h2);
        host.xfer({15'h0, 1'b1, cfg(4'h9, 8'h00)}, 17, 1, rsp);
        tx(cfg(4'h0, 8'h00), 17'h0D003);
        chk(firing_current_setting, 2'h2);
    endtask
    task automatic t_modes();
        spd = 3;
        for (int t = 0; t < 8; t++) begin
            n0 = n_diag;
            tx(par({MODE_DIAG, 1'b0, 1'b1, t[2:0], 9'h000}), NA);
            chk(diag_test_sel, t[2:0]);
            chk(n_diag - n0, 1);
        end
        for (int m = 0; m < 4; m++) begin
            n0 = n_mon;
            tx(par({MODE_MON, 1'b0, 1'b0, m[1:0], 10'h000}), NA);
            chk(monitor_sel, m[1:0]);
            chk(n_mon - n0, 1);
        end
        tx(par({MODE_CFG, 1'b0, 1'b1, 1'b0, 1'b1, 2'h3, 8'h00}), NA);
        chk(fire_latch_setting, 2'h3);
        chk(firing_current_setting, 2'h2);
        spd = 1;
    endtask
    task automatic t_deploy();
        n0 = n_fire;
        tx(dep(FIRE_PATTERN, 4'hF), NA);
        tx(dep(ARM_PATTERN, 4'h3), NA);
        tx(cfg(4'h0, 8'h00), NA);
        tx(dep(FIRE_PATTERN, 4'hF), NA);
        chk(n_fire - n0, 0);
        tx(dep(ARM_PATTERN, 4'h6), NA);
        tx(dep(FIRE_PATTERN, 4'hD), NA);
        chk(n_fire - n0, 1);
        chk(fire_channels, 4'h4);
    endtask
    task automatic t_regs();
        wb(1'b1, ADDR_CTRL, 32'h000000FE);
        wb(1'b0, ADDR_CTRL, 32'h00000000);
        chk(q, 32'h000000FE);
        // hold-off bit must mute the strobes but keep decoding
        wb(1'b1, ADDR_CTRL, 32'h00000001);
        n0 = n_diag;
        tx(par({MODE_DIAG, 1'b0, 1'b1, 3'h5, 9'h000}), NA);
        chk(n_diag - n0, 0);
        chk(spi_miso_oe, 1'b0);
        wb(1'b1, ADDR_CTRL, 32'h00000000);
        n0 = n_diag;
        tx(par({MODE_DIAG, 1'b0, 1'b1, 3'h6, 9'h000}), NA);
        chk(n_diag - n0, 1);
        chk(diag_test_sel, 3'h6);
        wb(1'b0, 4'h2, 32'h00000000);
        chk(q, 32'h00000000);
        wb(1'b0, ADDR_CMD, 32'h00000000);
        chk(q, {16'h0, last_w});
        wb(1'b0, ADDR_STATUS, 32'h00000000);
        chk(q[5], 1'b1);
    endtask
////////////////////////////////////////////////////////////
    initial begin
        {nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {failures, samples_checked, cycles, n_fire, n_diag, n_mon} = '0;
        spd = 1;
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (8) @(posedge ref_clk);
        t_config();
        t_soft_reset();
        t_faults();
        t_modes();
        t_deploy();
        t_regs();
        stop_test();
    end
endmodule // tb_squib_spi_command_decoder
